// >>> core/emp_ext_mem.sv
/*
  External memory paging interface: strobe timing with wait states,
  chip select decode with merges, two page registers and upper address
  control for 8-bit or 16-bit external SRAM or ROM.
  Assumes a processor that waits for cpu_ready and a register port
  on the same clock; memory data is stable when the strobe rises.
*/
`timescale 1ns/1ps
module emp_ext_mem
  import emp_pkg::*;
#(
  parameter int BOOT_CYCLES = EMP_BOOT_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  input  wire logic [1:0]  cpu_byte_en,
  input  wire logic        cpu_rd_req,
  input  wire logic        cpu_wr_req,
  input  wire logic        cpu_fetch,
  output logic             cpu_ready,
  output logic             cpu_ack,
  output logic             cpu_refused,
  output logic [15:0]      cpu_rdata,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic [18:0]      ext_addr,
  output logic [15:0]      ext_data_o,
  output logic             ext_data_oe,
  input  wire logic [15:0] ext_data_i,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             ext_window_select_n,
  output logic             ram_chip_select_n,
  output logic             rom_chip_select_n,
  output logic             low_byte_enable_n,
  output logic             high_byte_enable_n,
  output logic             boot_active
);

  import emp_pkg::*;

  typedef struct packed {
    emp_state_t              st;
    logic [15:0]             page_one;
    logic [15:0]             page_two;
    logic [EMP_CTRL_W-1:0]   ctrl;
    logic                    upper_en;
    logic                    hole;
    logic [17:0]             boot_cnt;
    logic                    boot_act;
    logic [EMP_WCNT_W-1:0]   wcnt;
    logic [EMP_WCNT_W-1:0]   wload;
    logic                    wide;
    logic                    lane;
    logic                    last;
    logic                    wr;
    logic [15:0]             wdata;
    logic [15:0]             rdata;
    logic                    ack;
    logic                    refused;
    logic [15:0]             reg_rdata;
    logic [18:0]             ext_addr;
    logic [15:0]             dout;
    logic                    dout_oe;
    logic                    wr_n;
    logic                    rd_n;
    logic                    xmem_n;
    logic                    ram_n;
    logic                    rom_n;
    logic                    bel_n;
    logic                    beh_n;
  } emp_regs_t;

  localparam emp_regs_t EMP_REGS_RST = '{
    st:       EMP_IDLE,
    page_one: EMP_PAGE_RST,
    page_two: EMP_PAGE_RST,
    ctrl:     EMP_CTRL_RST,
    boot_act: 1'b1,
    ext_addr: EMP_ADDR_RST,
    wr_n:     1'b1,
    rd_n:     1'b1,
    xmem_n:   1'b1,
    ram_n:    1'b1,
    rom_n:    1'b1,
    bel_n:    1'b1,
    beh_n:    1'b1,
    default:  '0
  };

  emp_regs_t   q;
  emp_regs_t   d;

  logic        xmem_hit;
  logic        page_two_hit;
  logic        ram_hit;
  logic        rom_hit;
  logic        hole_hit;
  logic        req;
  logic [1:0]  be_eff;
  logic [15:0] page_sel;
  logic [18:0] addr_calc;
  logic [15:0] rd_mux;
  logic        hole_set;
  logic        hole_clr;
  logic [3:0]  wait_units;

  emp_decode u_decode (
    .addr         (cpu_addr),
    .ram_merge    (q.ctrl[EMP_CTRL_RAMM_BIT]),
    .rom_merge    (q.ctrl[EMP_CTRL_ROMM_BIT]),
    .xmem_hit     (xmem_hit),
    .page_two_hit (page_two_hit),
    .ram_hit      (ram_hit),
    .rom_hit      (rom_hit),
    .hole_hit     (hole_hit)
  );

  // Only processor requests reach the pins; internal DMA has no port here
  assign req       = (cpu_rd_req || cpu_wr_req) && (q.st == EMP_IDLE);
  assign cpu_ready = (q.st == EMP_IDLE);

  always_comb
  begin
    be_eff = (cpu_byte_en == 2'b00) ? 2'b11 : cpu_byte_en;
    page_sel = page_two_hit ? q.page_two : q.page_one;
    if (xmem_hit)
    begin
      // Page supplies A18..A13, processor supplies the window offset
      addr_calc = {page_sel[EMP_PAGE_BITS-1:0], cpu_addr[EMP_PAGE_OFS_W-1:0]};
    end
    else
    begin
      addr_calc = {3'h0, cpu_addr};
    end
    if (!q.upper_en)
    begin
      addr_calc[18:15] = EMP_UPPER_IDLE;
    end
    if (q.ctrl[EMP_CTRL_WIDE_BIT])
    begin
      addr_calc[0] = 1'b0;
    end
    else
    begin
      addr_calc[0] = ~be_eff[0];
    end
    // One mandatory wait plus up to seven programmed ones
    wait_units = {1'b0, q.ctrl[EMP_CTRL_WAIT_LSB +: EMP_CTRL_WAIT_W]} + 4'h1;
  end

  always_comb
  begin
    unique case (reg_addr)
      EMP_PAGE_ONE_OFS: rd_mux = q.page_one;
      EMP_PAGE_TWO_OFS: rd_mux = q.page_two;
      EMP_CTRL_OFS:     rd_mux = {10'h000, q.ctrl};
      EMP_UPPER_EN_OFS: rd_mux = {15'h0000, q.upper_en};
      EMP_STATUS_OFS:   rd_mux = {13'h0000, q.boot_act, q.hole, (q.st != EMP_IDLE)};
      default:          rd_mux = 16'h0000;
    endcase
  end

  assign hole_clr = reg_wr && (reg_addr == EMP_STATUS_OFS) && reg_wdata[EMP_STAT_HOLE_BIT];
  assign hole_set = req && cpu_fetch && hole_hit;

  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    d.refused = 1'b0;
    d.reg_rdata = reg_rd ? rd_mux : 16'h0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        EMP_PAGE_ONE_OFS: d.page_one = reg_wdata;
        EMP_PAGE_TWO_OFS: d.page_two = reg_wdata;
        EMP_CTRL_OFS:     d.ctrl = reg_wdata[EMP_CTRL_W-1:0];
        EMP_UPPER_EN_OFS: d.upper_en = reg_wdata[EMP_UPPER_EN_BIT];
        default:          d.ctrl = q.ctrl;
      endcase
    end
    // A new hole fetch wins over a clear in the same cycle
    d.hole = hole_set || (q.hole && !hole_clr);

    if (q.boot_act)
    begin
      if (q.boot_cnt == 18'(BOOT_CYCLES - 1))
      begin
        d.boot_act = 1'b0;
      end
      d.boot_cnt = q.boot_cnt + 18'h00001;
    end

    unique case (q.st)
      EMP_IDLE:
      begin
        if (req)
        begin
          d.wr    = cpu_wr_req;
          d.wdata = cpu_wdata;
          d.rdata = 16'h0000;
          if ((cpu_fetch && hole_hit) || !(xmem_hit || ram_hit || rom_hit))
          begin
            // Nothing external answers here: finish at once with zero data
            d.ack     = 1'b1;
            d.refused = 1'b1;
            d.rdata   = 16'h0000;
          end
          else
          begin
            // Wait count is fixed for the whole access
            d.wload    = EMP_WCNT_W'(wait_units * EMP_WAIT_STEP_CYC - 1);
            d.wcnt     = EMP_WCNT_W'(wait_units * EMP_WAIT_STEP_CYC - 1);
            d.wide     = q.ctrl[EMP_CTRL_WIDE_BIT];
            d.lane     = ~be_eff[0];
            d.last     = q.ctrl[EMP_CTRL_WIDE_BIT] || (be_eff != 2'b11);
            d.ext_addr = addr_calc;
            d.xmem_n   = ~xmem_hit;
            d.ram_n    = ~ram_hit;
            d.rom_n    = ~rom_hit;
            d.dout_oe  = cpu_wr_req;
            if (q.ctrl[EMP_CTRL_WIDE_BIT])
            begin
              d.dout  = cpu_wdata;
              d.bel_n = cpu_wr_req ? ~be_eff[0] : 1'b0;
              d.beh_n = cpu_wr_req ? ~be_eff[1] : 1'b0;
            end
            else
            begin
              d.dout  = {8'h00, be_eff[0] ? cpu_wdata[7:0] : cpu_wdata[15:8]};
              d.bel_n = 1'b1;
              d.beh_n = 1'b1;
            end
            d.st = EMP_SETUP;
          end
        end
      end
      EMP_SETUP:
      begin
        d.wr_n = ~q.wr;
        d.rd_n = q.wr;
        d.st   = EMP_STROBE;
      end
      EMP_STROBE:
      begin
        if (q.wcnt == '0)
        begin
          // Strobe rises here and read data is taken on that edge
          d.wr_n = 1'b1;
          d.rd_n = 1'b1;
          if (!q.wr)
          begin
            if (q.wide)
            begin
              d.rdata = ext_data_i;
            end
            else if (q.lane)
            begin
              d.rdata[15:8] = ext_data_i[7:0];
            end
            else
            begin
              d.rdata[7:0] = ext_data_i[7:0];
            end
          end
          d.st = EMP_RELEASE;
        end
        else
        begin
          d.wcnt = q.wcnt - EMP_WCNT_W'(1);
        end
      end
      EMP_RELEASE:
      begin
        if (!q.last)
        begin
          // Second byte of a word on an 8-bit memory
          d.lane        = 1'b1;
          d.last        = 1'b1;
          d.ext_addr[0] = 1'b1;
          d.dout        = {8'h00, q.wdata[15:8]};
          d.wcnt        = q.wload;
          d.st          = EMP_SETUP;
        end
        else
        begin
          d.xmem_n  = 1'b1;
          d.ram_n   = 1'b1;
          d.rom_n   = 1'b1;
          d.bel_n   = 1'b1;
          d.beh_n   = 1'b1;
          d.dout_oe = 1'b0;
          d.ack     = 1'b1;
          d.st      = EMP_IDLE;
        end
      end
      default:
      begin
        d.st = EMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= EMP_REGS_RST;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign cpu_ack             = q.ack;
  assign cpu_refused         = q.refused;
  assign cpu_rdata           = q.rdata;
  assign reg_rdata           = q.reg_rdata;
  assign ext_addr            = q.ext_addr;
  assign ext_data_o          = q.dout;
  assign ext_data_oe         = q.dout_oe;
  assign write_strobe_n      = q.wr_n;
  assign read_strobe_n       = q.rd_n;
  assign ext_window_select_n = q.xmem_n;
  assign ram_chip_select_n   = q.ram_n;
  assign rom_chip_select_n   = q.rom_n;
  assign low_byte_enable_n   = q.bel_n;
  assign high_byte_enable_n  = q.beh_n;
  assign boot_active         = q.boot_act;

endmodule

// >>> core/emp_pkg.sv
/*
  Constants for the external memory paging interface: register offsets,
  field positions, reset values, address windows and timing counts.
  Assumes a 50 MHz core clock.
*/
package emp_pkg;

  // Register offsets
  localparam logic [15:0] EMP_PAGE_ONE_OFS  = 16'hC018;
  localparam logic [15:0] EMP_PAGE_TWO_OFS  = 16'hC01A;
  localparam logic [15:0] EMP_CTRL_OFS      = 16'hC03A;
  localparam logic [15:0] EMP_UPPER_EN_OFS  = 16'hC03C;
  localparam logic [15:0] EMP_STATUS_OFS    = 16'hC03E;

  // Control register fields
  localparam int          EMP_CTRL_W          = 6;
  localparam int          EMP_CTRL_WAIT_LSB   = 0;
  localparam int          EMP_CTRL_WAIT_W     = 3;
  localparam int          EMP_CTRL_WIDE_BIT   = 3;
  localparam int          EMP_CTRL_RAMM_BIT   = 4;
  localparam int          EMP_CTRL_ROMM_BIT   = 5;
  localparam logic [5:0]  EMP_CTRL_RST        = 6'h00;
  localparam int          EMP_UPPER_EN_BIT    = 0;

  // Status register fields
  localparam int          EMP_STAT_BUSY_BIT   = 0;
  localparam int          EMP_STAT_HOLE_BIT   = 1;
  localparam int          EMP_STAT_BOOT_BIT   = 2;

  localparam logic [15:0] EMP_PAGE_RST        = 16'h0000;

  // Processor address windows
  localparam logic [15:0] EMP_XMEM_LO   = 16'h8000;
  localparam logic [15:0] EMP_XMEM_HI   = 16'hBFFF;
  localparam logic [15:0] EMP_PAGE2_LO  = 16'hA000;
  localparam logic [15:0] EMP_RAM_LO    = 16'h4000;
  localparam logic [15:0] EMP_RAM_HI    = 16'h7FFF;
  localparam logic [15:0] EMP_ROM_LO    = 16'hC100;
  localparam logic [15:0] EMP_ROM_HI    = 16'hDFFF;
  localparam logic [15:0] EMP_HOLE_LO   = 16'hC000;
  localparam logic [15:0] EMP_HOLE_HI   = 16'hC0FF;

  // External address formation
  localparam int          EMP_PAGE_OFS_W  = 13;
  localparam int          EMP_PAGE_BITS   = 6;
  localparam logic [3:0]  EMP_UPPER_IDLE  = 4'hF;
  localparam logic [18:0] EMP_ADDR_RST    = 19'h78000;

  // Timing
  localparam int          EMP_CLK_MHZ       = 50;
  localparam int          EMP_WAIT_STEP_NS  = 21;
  localparam int          EMP_WAIT_STEP_CYC = (EMP_WAIT_STEP_NS * EMP_CLK_MHZ + 999) / 1000;
  localparam int          EMP_BOOT_TIME_US  = 3000;
  localparam int          EMP_BOOT_CYCLES   = EMP_BOOT_TIME_US * EMP_CLK_MHZ;
  localparam int          EMP_WCNT_W        = 5;

  typedef enum logic [3:0] {
    EMP_IDLE    = 4'b0001,
    EMP_SETUP   = 4'b0010,
    EMP_STROBE  = 4'b0100,
    EMP_RELEASE = 4'b1000
  } emp_state_t;

endpackage

// >>> core/emp_decode.sv
/*
  Chip select and window decoder for processor addresses.
  Assumes a 16-bit byte address from the processor and merge bits
  taken from the control register.
*/
`timescale 1ns/1ps
module emp_decode
  import emp_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic        ram_merge,
  input  wire logic        rom_merge,
  output logic             xmem_hit,
  output logic             page_two_hit,
  output logic             ram_hit,
  output logic             rom_hit,
  output logic             hole_hit
);

  logic in_xmem;
  logic in_ram;
  logic in_rom;

  always_comb
  begin
    in_xmem      = (addr >= EMP_XMEM_LO) && (addr <= EMP_XMEM_HI);
    in_ram       = (addr >= EMP_RAM_LO) && (addr <= EMP_RAM_HI);
    in_rom       = (addr >= EMP_ROM_LO) && (addr <= EMP_ROM_HI);
    hole_hit     = (addr >= EMP_HOLE_LO) && (addr <= EMP_HOLE_HI);
    // Merges never disturb the paging window
    xmem_hit     = in_xmem;
    page_two_hit = in_xmem && (addr >= EMP_PAGE2_LO);
    ram_hit      = in_ram || (ram_merge && in_xmem);
    // ROM merge spans 8000..DFFF but never the C000..C0FF hole
    rom_hit      = in_rom || (rom_merge && in_xmem);
  end

endmodule

// >>> tb/emp_ext_mem_asserts.sv
/*
  Pin checker for emp_ext_mem: strobes, selects, paging and refusals.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module emp_ext_mem_asserts
  import emp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_rd_req,
  input wire logic        cpu_wr_req,
  input wire logic        cpu_fetch,
  input wire logic        cpu_ready,
  input wire logic        cpu_ack,
  input wire logic        cpu_refused,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic [18:0] ext_addr,
  input wire logic        write_strobe_n,
  input wire logic        read_strobe_n,
  input wire logic        ext_window_select_n,
  input wire logic        ram_chip_select_n,
  input wire logic        rom_chip_select_n
);
  logic        take;
  logic [15:0] a_q;
  logic [5:0]  ctl_q;
  logic [5:0]  cfg_q;
  logic [5:0]  p1_q;
  logic [5:0]  p2_q;
  logic        up_q;
  logic [4:0]  lo_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  assign take = ce && cpu_ready && (cpu_rd_req || cpu_wr_req);

  // Register shadows, the address and control that the access in flight was taken with, and the read strobe length
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      a_q   <= 16'h0000;
      ctl_q <= 6'h00;
      cfg_q <= 6'h00;
      p1_q  <= 6'h00;
      p2_q  <= 6'h00;
      up_q  <= 1'b0;
      lo_q  <= 5'h00;
    end
    else if (ce)
    begin
      if (take)
        a_q <= cpu_addr;
      if (take)
        cfg_q <= ctl_q;
      if (reg_wr && reg_addr == EMP_CTRL_OFS)
        ctl_q <= reg_wdata[5:0];
      if (reg_wr && reg_addr == EMP_PAGE_ONE_OFS)
        p1_q <= reg_wdata[5:0];
      if (reg_wr && reg_addr == EMP_PAGE_TWO_OFS)
        p2_q <= reg_wdata[5:0];
      if (reg_wr && reg_addr == EMP_UPPER_EN_OFS)
        up_q <= reg_wdata[EMP_UPPER_EN_BIT];
      lo_q <= read_strobe_n ? 5'h00 : lo_q + 5'h01;
    end

  strobe_excl_a: assert property (read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  wr_min_a: assert property ($fell(write_strobe_n) |=> !write_strobe_n)
    else $error("write strobe too short");
  wait_len_a: assert property ($rose(read_strobe_n) |->
    lo_q == 5'(EMP_WAIT_STEP_CYC * (cfg_q[2:0] + 1)))
    else $error("read strobe length wrong");
  win_on_a: assert property (take && cpu_addr inside {[EMP_XMEM_LO:EMP_XMEM_HI]}
    |=> !ext_window_select_n)
    else $error("window select missing");
  win_rng_a: assert property (!ext_window_select_n |->
    a_q inside {[EMP_XMEM_LO:EMP_XMEM_HI]})
    else $error("window select out of range");
  ram_rng_a: assert property (!ram_chip_select_n |->
    a_q inside {[EMP_RAM_LO:EMP_RAM_HI]} ||
    cfg_q[EMP_CTRL_RAMM_BIT] && a_q inside {[EMP_RAM_LO:EMP_XMEM_HI]})
    else $error("ram select out of range");
  rom_rng_a: assert property (!rom_chip_select_n |->
    a_q inside {[EMP_ROM_LO:EMP_ROM_HI]} ||
    cfg_q[EMP_CTRL_ROMM_BIT] && a_q inside {[EMP_XMEM_LO:EMP_XMEM_HI]})
    else $error("rom select out of range");
  upper_idle_a: assert property (!up_q && !(read_strobe_n && write_strobe_n)
    |-> ext_addr[18:15] == EMP_UPPER_IDLE)
    else $error("upper lines not held high");
  page_map_a: assert property (up_q && !read_strobe_n && !ext_window_select_n
    |-> ext_addr[18:13] == (a_q < EMP_PAGE2_LO ? p1_q : p2_q))
    else $error("page bits wrong");
  hole_ref_a: assert property (take && cpu_fetch &&
    cpu_addr inside {[EMP_HOLE_LO:EMP_HOLE_HI]} |=> cpu_ack && cpu_refused)
    else $error("hole fetch not refused");
endmodule

bind emp_ext_mem emp_ext_mem_asserts u_chk (
  .sys_clk, .rst, .ce, .cpu_addr, .cpu_rd_req, .cpu_wr_req, .cpu_fetch,
  .cpu_ready, .cpu_ack, .cpu_refused, .reg_addr, .reg_wdata, .reg_wr,
  .ext_addr, .write_strobe_n, .read_strobe_n, .ext_window_select_n,
  .ram_chip_select_n, .rom_chip_select_n
);

// >>> tb/emp_sram_model.sv
/*
  Asynchronous 16-bit SRAM on the external memory pins.
  Assumes byte addresses and active-low select and lane enables.
*/
`timescale 1ns/1ps
module emp_sram_model
#(
  parameter int ACC_NS = 12
)
(
  input  wire logic [18:0] ext_addr,
  input  wire logic [15:0] ext_data_o,
  input  wire logic        sel_n,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        low_byte_enable_n,
  input  wire logic        high_byte_enable_n,
  output logic [15:0]      ext_data_i
);
  logic [15:0] mem [0:255];
  // Boot marker word at the C100 byte location
  initial mem[8'h80] = 16'hC3B6;
  logic [15:0] last_q = 16'h0000;
  wire  [7:0]  idx = ext_addr[8:1];

  always @(posedge write_strobe_n)
  begin
    if (!sel_n && !low_byte_enable_n)
      mem[idx][7:0] = ext_data_o[7:0];
    if (!sel_n && !high_byte_enable_n)
      mem[idx][15:8] = ext_data_o[15:8];
  end

  always @(posedge read_strobe_n)
    if (!sel_n)
      last_q = mem[idx];

  // A released bus shows the inverse of its last value
  assign #(ACC_NS) ext_data_i = (!read_strobe_n && !sel_n) ? mem[idx] : ~last_q;
endmodule

// >>> tb/emp_ext_mem_tb_top.sv
/*
  Self-checking bench for emp_ext_mem with an SRAM model on its pins.
  Assumes the checker is attached by the bind in its own file.
*/
`timescale 1ns/1ps
module emp_ext_mem_tb_top;
  import emp_pkg::*;

  typedef struct packed {
    logic [15:0] addr;
    logic [1:0]  merge;
    logic [2:0]  sel_n;
    logic        refused;
  } emp_row_t;

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic [15:0] cpu_wdata = 16'h0000;
  logic [1:0]  cpu_byte_en = 2'h3;
  logic        cpu_rd_req = 1'b0;
  logic        cpu_wr_req = 1'b0;
  logic        cpu_fetch = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        cpu_ready, cpu_ack, cpu_refused, boot_active;
  logic [15:0] cpu_rdata, reg_rdata, ext_data_o, ext_data_i;
  logic [18:0] ext_addr;
  logic        ext_data_oe;
  logic        oe;
  logic        ce = 1'b1;
  logic        write_strobe_n, read_strobe_n, low_byte_enable_n, high_byte_enable_n;
  logic        ext_window_select_n, ram_chip_select_n, rom_chip_select_n;
  int          failures = 0;
  int          tests_run = 0;
  int          lat;
  logic [4:0]  sel;
  logic [18:0] xa;
  logic        refd;
  logic [15:0] rd;
  logic [15:0] v;
  emp_row_t    rows [12] = '{
    {16'h4000, 2'h0, 3'h5, 1'h0}, {16'h7FFE, 2'h0, 3'h5, 1'h0},
    {16'h8000, 2'h0, 3'h3, 1'h0}, {16'hBFFE, 2'h0, 3'h3, 1'h0},
    {16'h9000, 2'h1, 3'h1, 1'h0}, {16'hA000, 2'h2, 3'h2, 1'h0},
    {16'h8000, 2'h3, 3'h0, 1'h0}, {16'hC100, 2'h0, 3'h6, 1'h0},
    {16'hDFFE, 2'h2, 3'h6, 1'h0}, {16'hC0FE, 2'h3, 3'h7, 1'h1},
    {16'h3FFE, 2'h3, 3'h7, 1'h1}, {16'hE000, 2'h3, 3'h7, 1'h1}};

  always #10 sys_clk = ~sys_clk;

  emp_ext_mem #(
    .BOOT_CYCLES (20)
  ) dut (
    .sys_clk, .rst, .ce, .cpu_addr, .cpu_wdata, .cpu_byte_en,
    .cpu_rd_req, .cpu_wr_req, .cpu_fetch, .cpu_ready, .cpu_ack, .cpu_refused,
    .cpu_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_addr, .ext_data_o, .ext_data_oe, .ext_data_i, .write_strobe_n,
    .read_strobe_n, .ext_window_select_n, .ram_chip_select_n,
    .rom_chip_select_n, .low_byte_enable_n, .high_byte_enable_n, .boot_active
  );

  emp_sram_model u_mem (
    .ext_addr, .ext_data_o, .write_strobe_n, .read_strobe_n,
    .sel_n (ext_window_select_n & ram_chip_select_n & rom_chip_select_n),
    .low_byte_enable_n, .high_byte_enable_n, .ext_data_i
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic rw(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rr(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // One processor access, the only requester: no DMA ever aims here
  // Pins are sampled in the cycle after the access is taken
  task automatic acc(input logic [15:0] a, input logic w, input logic f,
                     input logic [1:0] be, input logic [15:0] d);
    @(posedge sys_clk);
    cpu_addr    <= a;
    cpu_wr_req  <= w;
    cpu_rd_req  <= !w;
    cpu_fetch   <= f;
    cpu_byte_en <= be;
    cpu_wdata   <= d;
    @(posedge sys_clk);
    cpu_wr_req  <= 1'b0;
    cpu_rd_req  <= 1'b0;
    #1;
    lat = 1;
    sel = {ext_window_select_n, ram_chip_select_n, rom_chip_select_n,
           high_byte_enable_n, low_byte_enable_n};
    xa  = ext_addr;
    oe  = ext_data_oe;
    while (cpu_ack !== 1'b1 && lat < 40)
    begin
      @(posedge sys_clk);
      #1 lat++;
    end
    chk(cpu_ack, 1'b1);
    refd = cpu_refused;
    rd   = cpu_rdata;
  endtask

  task automatic summarize;
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(ext_addr, 32'h78000);
    chk(boot_active, 1);
    chk(cpu_ready, 1);
    foreach (rows[i])
    begin
      rw(EMP_CTRL_OFS, {10'h000, rows[i].merge, 4'h8});
      acc(rows[i].addr, 1'b0, 1'b0, 2'h3, 16'h0000);
      chk(sel[4:2], rows[i].sel_n);
      chk(refd, rows[i].refused);
      chk(lat, rows[i].refused ? 1 : 5);
      chk(xa[18:15], 4'hF);
      chk(oe, 0);
    end
    chk(boot_active, 0);
    for (int w = 0; w < 8; w++)
    begin
      rw(EMP_CTRL_OFS, 16'(8 + w));
      acc(16'h4000, 1'b0, 1'b0, 2'h3, 16'h0000);
      chk(lat, EMP_WAIT_STEP_CYC * (w + 1) + 3);
    end
    rw(EMP_PAGE_ONE_OFS, 16'h0005);
    rw(EMP_PAGE_TWO_OFS, 16'h003F);
    rw(EMP_UPPER_EN_OFS, 16'h0001);
    rw(EMP_CTRL_OFS, 16'h0008);
    rr(EMP_PAGE_TWO_OFS, v);
    chk(v, 16'h003F);
    acc(16'h8000, 1'b0, 1'b0, 2'h3, 16'h0000);
    chk(xa, 19'h0A000);
    acc(16'hA002, 1'b0, 1'b0, 2'h3, 16'h0000);
    chk(xa, 19'h7E002);
    acc(16'hC100, 1'b0, 1'b0, 2'h3, 16'h0000);
    chk(rd, 16'hC3B6);
    // A register write while the clock enable is low must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    rw(EMP_PAGE_ONE_OFS, 16'h0011);
    ce <= 1'b1;
    rr(EMP_PAGE_ONE_OFS, v);
    chk(v, 16'h0005);
    acc(16'h4010, 1'b1, 1'b0, 2'h3, 16'h1234);
    chk(oe, 1);
    acc(16'h4010, 1'b1, 1'b0, 2'h1, 16'hAB55);
    chk(sel[1:0], 2'h2);
    acc(16'h4010, 1'b0, 1'b0, 2'h3, 16'h0000);
    chk(rd, 16'h1255);
    // 8-bit mode: two byte phases, both lanes off; the part sits on D7:0
    rw(EMP_CTRL_OFS, 16'h0000);
    acc(16'h4010, 1'b0, 1'b0, 2'h3, 16'h0000);
    chk(lat, 2 * (EMP_WAIT_STEP_CYC + 2) + 1);
    chk(sel[1:0], 2'h3);
    chk(rd, 16'h5555);
    acc(16'hC010, 1'b0, 1'b1, 2'h3, 16'h0000);
    chk(refd, 1);
    rr(EMP_STATUS_OFS, v);
    chk(v[EMP_STAT_HOLE_BIT], 1);
    rw(EMP_STATUS_OFS, 16'(1 << EMP_STAT_HOLE_BIT));
    rr(EMP_STATUS_OFS, v);
    chk(v[EMP_STAT_HOLE_BIT], 0);
    rr(16'hC000, v);
    chk(v, 0);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(ext_addr, 32'h78000);
    chk(boot_active, 1);
    rst <= 1'b0;
    rr(EMP_PAGE_ONE_OFS, v);
    chk(v, 0);
    summarize();
  end

  initial
  begin
    #(20 * 10000);
    failures++;
    summarize();
  end
endmodule
